// *** hw/gpio_cell_pkg.sv ***
// shared constants for the general-purpose i/o logic cell
`default_nettype none
package gpio_cell_pkg;

  // wishbone geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;

  // control register field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_IN_REG_BIT = 2;
  localparam int CTRL_OUT_REG_BIT = 3;
  localparam int CTRL_OE_REG_BIT = 4;
  localparam int CTRL_IN_FALL_BIT = 5;
  localparam int CTRL_OUT_FALL_BIT = 6;
  localparam int CTRL_OE_FALL_BIT = 7;
  localparam int CTRL_INVERT_BIT = 8;
  localparam int CTRL_DOUBLE_EDGE_IO_BIT = 9;
  localparam int CTRL_RESYNC_BIT = 10;
  localparam int CTRL_PULLDOWN_BIT = 11;
  localparam int CTRL_DIFF_SE_BIT = 12;
  localparam int CTRL_USED_BIT = 13;
  localparam int CTRL_ALT_LSB = 14;
  localparam int CTRL_CONFIGURING_BIT = 16;
  localparam int CTRL_WIDTH = 17;

  // status register field positions
  localparam int STAT_PAD_BIT = 0;
  localparam int STAT_OE_BIT = 1;
  localparam int STAT_DOUBLE_EDGE_IO_REJ_BIT = 2;
  localparam int STAT_PD_REJ_BIT = 3;
  localparam int STAT_WORD_LSB = 4;

  // control reset value: input mode, unused pin, configuration in progress
  localparam logic [16:0] CTRL_RESET = 17'h10000;

  // alternate input destinations, one bit each on the route vector
  localparam int ALT_GLOBAL_CLOCK = 0;
  localparam int ALT_GLOBAL_CONTROL = 1;
  localparam int ALT_PLL_REFERENCE = 2;
  localparam int ALT_CAMERA_CLOCK = 3;
  localparam int ALT_ROUTES = 4;

  // double-edge word width per direction
  localparam int WORD_W = 2;

  // pin operating modes
  typedef enum logic [1:0] {
    MODE_INPUT,
    MODE_OUTPUT,
    MODE_BIDIR,
    MODE_CLOCK_OUT
  } mode_type;

endpackage

`default_nettype wire

// *** hw/gpio_cell.sv ***
// general-purpose i/o logic cell with wishbone configuration port
//
// Added by the designer: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module gpio_cell (
  // system
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // core side
  input wire logic i_input_register_clock,
  input wire logic i_output_register_clock,
  input wire logic i_core_clock_tree,
  input wire logic i_pad_output_rise_bit,
  input wire logic i_pad_output_fall_bit,
  input wire logic i_out_enable,
  output logic o_pad_input_rise_bit,
  output logic o_pad_input_fall_bit,
  // alternate input
  output logic o_alternate_input,
  output logic [3:0] o_alt_route,
  // pad side
  input wire logic i_pad,
  output logic o_pad,
  output logic o_pad_oe,
  output logic o_pull_up,
  output logic o_pull_down
);

  logic [16:0] ctrl_ff;
  logic double_edge_io_rej_ff;
  logic pd_rej_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic in_clk_q_ff;
  logic out_clk_q_ff;
  logic in_rise;
  logic in_fall;
  logic out_rise;
  logic out_fall;
  logic in_cap;
  logic out_cap;
  logic oe_cap;
  logic in_sdr_ff;
  logic in_rise_ff;
  logic in_fall_ff;
  logic rs_rise_ff;
  logic rs_fall_ff;
  logic [1:0] in_word_ff;
  logic [1:0] nxt_in_word;
  logic out_sdr_ff;
  logic od_rise_ff;
  logic od_fall_ff;
  logic od_pend_ff;
  logic oe_reg_ff;
  logic oe_eff;
  logic out_val;
  logic nxt_pad;
  logic nxt_pad_oe;
  logic pad_ff;
  logic pad_oe_ff;
  logic wr_ctrl;
  logic wr_status;
  logic [16:0] wr_val;
  logic [16:0] clean_val;
  logic rej_double_edge_io_now;
  logic rej_pd_now;
  gpio_cell_pkg::mode_type mode;
  logic in_reg_en;
  logic out_reg_en;
  logic oe_reg_en;
  logic double_edge_io_en;
  logic resync_en;
  logic diff_se;
  logic pin_used;
  logic configuring;
  logic in_path_on;
  logic alt_on;

  // byte-lane merge of a write onto the current control value
  function automatic logic [16:0] merge_bytes(input logic [16:0] old_v,
                                              input logic [31:0] dat,
                                              input logic [3:0] sel);
    logic [31:0] res;
    res = {15'h0000, old_v};
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return res[16:0];
  endfunction

  // field views of the control register
  assign mode = gpio_cell_pkg::mode_type'(ctrl_ff[gpio_cell_pkg::CTRL_MODE_LSB +: 2]);
  assign in_reg_en = ctrl_ff[gpio_cell_pkg::CTRL_IN_REG_BIT];
  assign out_reg_en = ctrl_ff[gpio_cell_pkg::CTRL_OUT_REG_BIT];
  assign oe_reg_en = ctrl_ff[gpio_cell_pkg::CTRL_OE_REG_BIT];
  assign double_edge_io_en = ctrl_ff[gpio_cell_pkg::CTRL_DOUBLE_EDGE_IO_BIT];
  assign resync_en = ctrl_ff[gpio_cell_pkg::CTRL_RESYNC_BIT];
  assign diff_se = ctrl_ff[gpio_cell_pkg::CTRL_DIFF_SE_BIT];
  assign pin_used = ctrl_ff[gpio_cell_pkg::CTRL_USED_BIT];
  assign configuring = ctrl_ff[gpio_cell_pkg::CTRL_CONFIGURING_BIT];

  // bus decode; unmapped addresses still get an ack
  assign wr_ctrl = i_wb_cyc && i_wb_stb && i_wb_we && !ack_ff
                   && (i_wb_adr == gpio_cell_pkg::CTRL_OFFSET);
  assign wr_status = i_wb_cyc && i_wb_stb && i_wb_we && !ack_ff
                     && (i_wb_adr == gpio_cell_pkg::STATUS_OFFSET);
  assign wr_val = merge_bytes(ctrl_ff, i_wb_dat, i_wb_sel);

  // illegal combinations on differential-pair pins are stripped on write
  always_comb begin
    clean_val = wr_val;
    rej_double_edge_io_now = 1'b0;
    rej_pd_now = 1'b0;
    if (wr_val[gpio_cell_pkg::CTRL_DIFF_SE_BIT]) begin
      if (wr_val[gpio_cell_pkg::CTRL_DOUBLE_EDGE_IO_BIT]) begin
        clean_val[gpio_cell_pkg::CTRL_DOUBLE_EDGE_IO_BIT] = 1'b0;
        rej_double_edge_io_now = 1'b1;
      end
      if (wr_val[gpio_cell_pkg::CTRL_PULLDOWN_BIT]) begin
        clean_val[gpio_cell_pkg::CTRL_PULLDOWN_BIT] = 1'b0;
        rej_pd_now = 1'b1;
      end
    end
  end

  // control register
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl_ff <= gpio_cell_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_ff <= clean_val;
    end
  end

  // sticky reject flags; a new reject wins over write-one-to-clear
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      double_edge_io_rej_ff <= 1'b0;
      pd_rej_ff <= 1'b0;
    end else begin
      if (wr_ctrl && rej_double_edge_io_now) begin
        double_edge_io_rej_ff <= 1'b1;
      end else if (wr_status && i_wb_sel[0] && i_wb_dat[gpio_cell_pkg::STAT_DOUBLE_EDGE_IO_REJ_BIT]) begin
        double_edge_io_rej_ff <= 1'b0;
      end
      if (wr_ctrl && rej_pd_now) begin
        pd_rej_ff <= 1'b1;
      end else if (wr_status && i_wb_sel[0] && i_wb_dat[gpio_cell_pkg::STAT_PD_REJ_BIT]) begin
        pd_rej_ff <= 1'b0;
      end
    end
  end

  // ack one cycle after the strobe, dropped the next cycle
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= i_wb_cyc && i_wb_stb && !ack_ff;
      if (i_wb_cyc && i_wb_stb && !ack_ff && !i_wb_we) begin
        if (i_wb_adr == gpio_cell_pkg::CTRL_OFFSET) begin
          rdata_ff <= {15'h0000, ctrl_ff};
        end else if (i_wb_adr == gpio_cell_pkg::STATUS_OFFSET) begin
          rdata_ff <= {26'h0000000, in_word_ff, pd_rej_ff, double_edge_io_rej_ff, oe_eff, i_pad};
        end else begin
          rdata_ff <= 32'h00000000;
        end
      end
    end
  end

  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdata_ff;

  // register clocks arrive as levels; edges become one-cycle enables
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      in_clk_q_ff <= 1'b0;
      out_clk_q_ff <= 1'b0;
    end else begin
      in_clk_q_ff <= i_input_register_clock;
      out_clk_q_ff <= i_output_register_clock;
    end
  end

  assign in_rise = i_input_register_clock && !in_clk_q_ff;
  assign in_fall = !i_input_register_clock && in_clk_q_ff;
  assign out_rise = i_output_register_clock && !out_clk_q_ff;
  assign out_fall = !i_output_register_clock && out_clk_q_ff;
  // each register picks its own edge polarity
  assign in_cap = ctrl_ff[gpio_cell_pkg::CTRL_IN_FALL_BIT] ? in_fall : in_rise;
  assign out_cap = ctrl_ff[gpio_cell_pkg::CTRL_OUT_FALL_BIT] ? out_fall : out_rise;
  assign oe_cap = ctrl_ff[gpio_cell_pkg::CTRL_OE_FALL_BIT] ? out_fall : out_rise;

  // input registers capture the pad before the core sees it
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      in_sdr_ff <= 1'b0;
      in_rise_ff <= 1'b0;
      in_fall_ff <= 1'b0;
      rs_rise_ff <= 1'b0;
      rs_fall_ff <= 1'b0;
    end else begin
      if (in_cap) begin
        in_sdr_ff <= i_pad;
      end
      if (in_rise) begin
        in_rise_ff <= i_pad;
        // resync: falling sample handed over half a cycle later
        rs_rise_ff <= i_pad;
        rs_fall_ff <= in_fall_ff;
      end
      if (in_fall) begin
        in_fall_ff <= i_pad;
      end
    end
  end

  // input path is live only in input and bidirectional modes of a used pin
  assign in_path_on = pin_used && (mode == gpio_cell_pkg::MODE_INPUT
                      || mode == gpio_cell_pkg::MODE_BIDIR);

  // selection of the word handed to the core
  always_comb begin
    nxt_in_word = 2'h0;
    if (in_path_on) begin
      if (in_reg_en && double_edge_io_en && resync_en) begin
        nxt_in_word = {rs_fall_ff, rs_rise_ff};
      end else if (in_reg_en && double_edge_io_en) begin
        nxt_in_word = {in_fall_ff, in_rise_ff};
      end else if (in_reg_en) begin
        nxt_in_word = {1'b0, in_sdr_ff};
      end else begin
        nxt_in_word = {1'b0, i_pad};
      end
    end
  end

  // two-bit word toward the core
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      in_word_ff <= 2'h0;
    end else begin
      in_word_ff <= nxt_in_word;
    end
  end

  assign o_pad_input_rise_bit = in_word_ff[0];
  assign o_pad_input_fall_bit = in_word_ff[1];

  // alternate path: unregistered input mode only, never through a register
  assign alt_on = pin_used && mode == gpio_cell_pkg::MODE_INPUT && !in_reg_en;
  assign o_alternate_input = alt_on && i_pad;

  // one-hot steering of the alternate input to its destination
  generate
    for (genvar r = 0; r < gpio_cell_pkg::ALT_ROUTES; r++) begin : g_alt
      assign o_alt_route[r] = alt_on
        && (ctrl_ff[gpio_cell_pkg::CTRL_ALT_LSB +: 2] == 2'(r));
    end
  endgenerate

  // output and enable registers hold core values before the pad buffer
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      out_sdr_ff <= 1'b0;
      od_rise_ff <= 1'b0;
      od_fall_ff <= 1'b0;
      od_pend_ff <= 1'b0;
      oe_reg_ff <= 1'b0;
    end else begin
      if (out_cap) begin
        out_sdr_ff <= i_pad_output_rise_bit;
      end
      if (oe_cap) begin
        oe_reg_ff <= i_out_enable;
      end
      if (out_rise) begin
        od_rise_ff <= i_pad_output_rise_bit;
        // resync takes both bits on the rising edge
        od_pend_ff <= i_pad_output_fall_bit;
      end
      if (out_fall) begin
        od_fall_ff <= resync_en ? od_pend_ff : i_pad_output_fall_bit;
      end
    end
  end

  // data value presented to the pad driver
  always_comb begin
    out_val = i_pad_output_rise_bit;
    if (out_reg_en && double_edge_io_en) begin
      // high phase shows the rising bit, low phase the falling bit
      out_val = i_output_register_clock ? od_rise_ff : od_fall_ff;
    end else if (out_reg_en) begin
      out_val = out_sdr_ff;
    end
    if (out_reg_en && ctrl_ff[gpio_cell_pkg::CTRL_INVERT_BIT]) begin
      out_val = !out_val;
    end
  end

  assign oe_eff = oe_reg_en ? oe_reg_ff : i_out_enable;

  // pad driver per mode; unused or configuring pins stay released
  always_comb begin
    nxt_pad = 1'b0;
    nxt_pad_oe = 1'b0;
    if (pin_used && !configuring) begin
      case (mode)
        gpio_cell_pkg::MODE_INPUT: begin
          nxt_pad_oe = 1'b0;
        end
        gpio_cell_pkg::MODE_OUTPUT: begin
          nxt_pad = out_val;
          nxt_pad_oe = 1'b1;
        end
        gpio_cell_pkg::MODE_BIDIR: begin
          nxt_pad = out_val;
          nxt_pad_oe = oe_eff;
        end
        default: begin
          nxt_pad = i_core_clock_tree;
          nxt_pad_oe = 1'b1;
        end
      endcase
    end
  end

  // pad drive flip-flops
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      pad_ff <= 1'b0;
      pad_oe_ff <= 1'b0;
    end else begin
      pad_ff <= nxt_pad;
      pad_oe_ff <= nxt_pad_oe;
    end
  end

  assign o_pad = pad_ff;
  assign o_pad_oe = pad_oe_ff;

  // weak pulls: up while configuring a single-ended pin, chosen pull on unused pins
  always_comb begin
    o_pull_up = 1'b0;
    o_pull_down = 1'b0;
    if (configuring) begin
      o_pull_up = !diff_se;
    end else if (!pin_used) begin
      // pair pins have no pull-down resistor at all
      o_pull_down = ctrl_ff[gpio_cell_pkg::CTRL_PULLDOWN_BIT] && !diff_se;
      o_pull_up = !o_pull_down;
    end
  end

endmodule

`default_nettype wire

// *** test/gpio_cell_props.sv ***
// assertion checker for the gpio cell ports
`timescale 1ns/10ps
`default_nettype none
module gpio_cell_props (
  // system
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  input wire logic o_wb_ack,
  // core and pad
  input wire logic i_pad_output_rise_bit,
  input wire logic i_out_enable,
  input wire logic i_core_clock_tree,
  input wire logic o_pad_input_rise_bit,
  input wire logic o_alternate_input,
  input wire logic [3:0] o_alt_route,
  input wire logic i_pad,
  input wire logic o_pad,
  input wire logic o_pad_oe,
  input wire logic o_pull_up,
  input wire logic o_pull_down
);
  logic [16:0] ctrl_ff;
  logic [16:0] nxt_ctrl;
  logic live;
  logic [1:0] md;

  // shadow control word, byte lanes merged as the cell does
  assign nxt_ctrl = {i_wb_sel[2] ? i_wb_dat[16] : ctrl_ff[16],
    i_wb_sel[1] ? i_wb_dat[15:8] : ctrl_ff[15:8], i_wb_sel[0] ? i_wb_dat[7:0] : ctrl_ff[7:0]};
  assign live = ctrl_ff[13] && !ctrl_ff[16];
  assign md = ctrl_ff[1:0];

  // write lands at the edge that takes the request
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      ctrl_ff <= gpio_cell_pkg::CTRL_RESET;
    end else if (i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack &&
                 i_wb_adr == gpio_cell_pkg::CTRL_OFFSET) begin
      // pair pins lose double-edge and pull-down, as the cell strips them
      ctrl_ff <= nxt_ctrl & ~({17{nxt_ctrl[12]}} & 17'h00A00);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_pulse;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  property p_ack_once;
    s_req |=> s_pulse;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack timing wrong");
  property p_rst;
    disable iff (1'b0) i_sys_rst |=> o_pull_up && !o_pad_oe && !o_wb_ack && o_alt_route == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_cfg_pull;
    ctrl_ff[16] && !ctrl_ff[12] |-> o_pull_up && !o_pull_down;
  endproperty
  a_cfg_pull: assert property (p_cfg_pull) else $error("no pull-up while configuring");
  property p_unused_pd;
    !ctrl_ff[13] && !ctrl_ff[16] && ctrl_ff[11] && !ctrl_ff[12] |-> o_pull_down && !o_pull_up;
  endproperty
  a_unused_pd: assert property (p_unused_pd) else $error("pull-down not chosen");
  property p_no_drive;
    !live |=> !o_pad_oe;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("idle pin driven");
  property p_in_only;
    live && md == gpio_cell_pkg::MODE_INPUT |=> !o_pad_oe;
  endproperty
  a_in_only: assert property (p_in_only) else $error("input mode drives pad");
  property p_in_unreg;
    live && md == gpio_cell_pkg::MODE_INPUT && !ctrl_ff[2] && !ctrl_ff[9]
      |=> o_pad_input_rise_bit == $past(i_pad);
  endproperty
  a_in_unreg: assert property (p_in_unreg) else $error("input path wrong");
  property p_out_unreg;
    live && md == gpio_cell_pkg::MODE_OUTPUT && !ctrl_ff[3] && !ctrl_ff[9]
      |=> o_pad_oe && o_pad == $past(i_pad_output_rise_bit);
  endproperty
  a_out_unreg: assert property (p_out_unreg) else $error("output path wrong");
  property p_bidir_oe;
    live && md == gpio_cell_pkg::MODE_BIDIR && !ctrl_ff[4] |=> o_pad_oe == $past(i_out_enable);
  endproperty
  a_bidir_oe: assert property (p_bidir_oe) else $error("enable not followed");
  property p_clk_out;
    live && md == gpio_cell_pkg::MODE_CLOCK_OUT |=> o_pad_oe && o_pad == $past(i_core_clock_tree);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock not driven");
  property p_alt_route;
    live && md == gpio_cell_pkg::MODE_INPUT && !ctrl_ff[2] |-> o_alt_route == 4'h1 << ctrl_ff[15:14];
  endproperty
  a_alt_route: assert property (p_alt_route) else $error("alternate route wrong");
  property p_alt_gate;
    o_alt_route != 4'h0 |-> o_alternate_input == i_pad;
  endproperty
  a_alt_gate: assert property (p_alt_gate) else $error("alternate not the pad");
endmodule

bind gpio_cell gpio_cell_props u_gpio_cell_props (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_dat(i_wb_dat), .i_wb_sel(i_wb_sel), .o_wb_ack(o_wb_ack),
  .i_pad_output_rise_bit(i_pad_output_rise_bit), .i_out_enable(i_out_enable),
  .i_core_clock_tree(i_core_clock_tree), .o_pad_input_rise_bit(o_pad_input_rise_bit),
  .o_alternate_input(o_alternate_input), .o_alt_route(o_alt_route), .i_pad(i_pad),
  .o_pad(o_pad), .o_pad_oe(o_pad_oe), .o_pull_up(o_pull_up), .o_pull_down(o_pull_down));
`default_nettype wire

// *** test/core_fabric_model.sv ***
// core fabric model: register clocks and a stepping data pattern
`timescale 1ns/10ps
`default_nettype none
module core_fabric_model (
  // system
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  // pace
  input wire logic i_run,
  input wire logic i_slow,
  // toward the cell
  output logic o_in_clk,
  output logic o_out_clk,
  output logic o_tree,
  output logic o_rise,
  output logic o_fall,
  output logic o_oe,
  output logic [2:0] o_phase
);
  logic [2:0] phase_ff;
  logic [2:0] pat_ff;
  logic hold_ff;

  // four steps a phase; slow pace halves the step rate
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      phase_ff <= 3'h0;
      pat_ff <= 3'h0;
      hold_ff <= 1'h0;
    end else if (i_run) begin
      hold_ff <= i_slow && !hold_ff;
      if (hold_ff || !i_slow) begin
        phase_ff <= phase_ff + 3'h1;
        // data moves at the start of the last low-phase step, clear of both capture edges
        if (phase_ff == 3'h2) begin
          pat_ff <= pat_ff + 3'h1;
        end
      end
    end
  end

  // outputs
  assign o_in_clk = phase_ff[2];
  assign o_out_clk = phase_ff[2];
  assign o_tree = phase_ff[1];
  assign o_rise = pat_ff[0];
  assign o_fall = pat_ff[1];
  assign o_oe = pat_ff[2];
  assign o_phase = phase_ff;
endmodule
`default_nettype wire

// *** test/gpio_cell_tb.sv ***
// self-checking bench for the gpio cell
`timescale 1ns/10ps
`default_nettype none
module gpio_cell_tb;
  logic clk, rst, cyc, stb, we, ack, run, slow, ext_val, er, ef;
  logic [7:0] adr;
  logic [31:0] dat, wb_q, rdat;
  logic [3:0] sel, alt_route;
  logic in_clk, out_clk, tree, d_rise, d_fall, d_oe, q_rise, q_fall, alt_in;
  logic pad_w, pad_o, pad_oe, pu, pd;
  logic [2:0] ph;
  logic [1:0] pk;
  int miscompares, comparisons;

  // cell drive wins; the bench drives the pad otherwise
  assign pad_w = pad_oe ? pad_o : ext_val;

  gpio_cell u_gpio_cell (.i_clk_sys(clk), .i_sys_rst(rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(dat), .i_wb_sel(sel), .o_wb_dat(wb_q),
    .o_wb_ack(ack), .i_input_register_clock(in_clk), .i_output_register_clock(out_clk),
    .i_core_clock_tree(tree), .i_pad_output_rise_bit(d_rise), .i_pad_output_fall_bit(d_fall),
    .i_out_enable(d_oe), .o_pad_input_rise_bit(q_rise), .o_pad_input_fall_bit(q_fall),
    .o_alternate_input(alt_in), .o_alt_route(alt_route), .i_pad(pad_w), .o_pad(pad_o),
    .o_pad_oe(pad_oe), .o_pull_up(pu), .o_pull_down(pd));

  core_fabric_model u_core_fabric_model (.i_clk_sys(clk), .i_sys_rst(rst), .i_run(run),
    .i_slow(slow), .o_in_clk(in_clk), .o_out_clk(out_clk), .o_tree(tree), .o_rise(d_rise),
    .o_fall(d_fall), .o_oe(d_oe), .o_phase(ph));

  // 100 MHz system clock
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    miscompares++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish();
  endtask

  // one classic cycle; request held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    rdat = wb_q;
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n >= 20) give_up();
  endtask

  // returns at the end of a cycle spent in phase p
  task automatic wait_ph(input logic [2:0] p);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ph !== p && n < 40);
    if (n >= 40) give_up();
  endtask

  initial begin
    rst = 1'h1;
    {cyc, stb, we, run, slow, ext_val} = 6'h00;
    adr = 8'h00;
    dat = 32'h0;
    sel = 4'h0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    run <= 1'h1;
    bus(1'h0, 8'h00, 32'h0);
    check(rdat, 32'h00010000);
    check(pu, 1'h1);
    bus(1'h1, 8'h08, 32'hFFFFFFFF);
    bus(1'h0, 8'h08, 32'h0);
    check(rdat, 32'h0);
    bus(1'h1, 8'h00, 32'h00000800);
    check({pu, pd}, 2'h1);
    bus(1'h1, 8'h00, 32'h00001A00);
    check({pu, pd}, 2'h2);
    bus(1'h0, 8'h04, 32'h0);
    check(rdat & 32'hC, 32'hC);
    bus(1'h1, 8'h04, 32'hC);
    bus(1'h0, 8'h04, 32'h0);
    check(rdat & 32'hC, 32'h0);
    // pair pin while configuring gets no pull-up
    bus(1'h1, 8'h00, 32'h00011000);
    check({pu, pd}, 2'h0);
    bus(1'h1, 8'h00, 32'h00002001);
    wait_ph(3'h5);
    check({pad_oe, pad_o}, {1'h1, d_rise});
    bus(1'h1, 8'h00, 32'h00002109);
    wait_ph(3'h0);
    wait_ph(3'h7);
    check(pad_o, !d_rise);
    // double-edge output, every pattern of the pair
    bus(1'h1, 8'h00, 32'h0000220A);
    wait_ph(3'h0);
    for (int k = 0; k < 4; k++) begin
      wait_ph(3'h5);
      er = d_rise;
      ef = d_fall;
      wait_ph(3'h7);
      check(pad_o, er);
      wait_ph(3'h3);
      check(pad_o, ef);
    end
    // double-edge input, normal sub-mode
    bus(1'h1, 8'h00, 32'h00002204);
    for (int k = 0; k < 4; k++) begin
      wait_ph(3'h2);
      ext_val <= k[0];
      wait_ph(3'h6);
      ext_val <= k[1];
      wait_ph(3'h3);
      check({q_fall, q_rise}, k[1:0]);
    end
    // resync: the fall sample waits for the next rise
    slow <= 1'h1;
    bus(1'h1, 8'h00, 32'h00002604);
    for (int k = 0; k < 5; k++) begin
      wait_ph(3'h6);
      ext_val <= k[1];
      wait_ph(3'h2);
      ext_val <= k[0];
      wait_ph(3'h3);
      if (k > 0) check({q_fall, q_rise}, pk);
      pk = k[1:0];
    end
    // bidirectional: released pad still read back
    bus(1'h1, 8'h00, 32'h00002002);
    for (int k = 0; k < 8; k++) begin
      wait_ph(3'h3);
      ext_val <= k[0];
      wait_ph(3'h6);
      check(pad_oe, d_oe);
      check(q_rise, d_oe ? d_rise : k[0]);
    end
    // registered input on the falling edge of its clock
    bus(1'h1, 8'h00, 32'h00002024);
    for (int k = 0; k < 4; k++) begin
      wait_ph(3'h5);
      ext_val <= k[0];
      wait_ph(3'h2);
      check({q_fall, q_rise}, {1'h0, k[0]});
    end
    // output and enable registers launched on the falling edge
    bus(1'h1, 8'h00, 32'h000020DA);
    for (int k = 0; k < 4; k++) begin
      wait_ph(3'h2);
      er = d_rise;
      ef = d_oe;
      wait_ph(3'h7);
      check({pad_oe, pad_o}, {ef, er});
    end
    bus(1'h1, 8'h00, 32'h00002003);
    wait_ph(3'h5);
    check(pad_oe, 1'h1);
    for (int k = 0; k < 4; k++) begin
      bus(1'h1, 8'h00, {16'h0000, k[1:0], 14'h2000});
      check(alt_route, 4'h1 << k);
      check(alt_in, pad_w);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
